// ==== pkg/asb_pkg.sv ====
// package: offsets, field positions, reset values and operation codes of the status bank
package asb_pkg;
	localparam int unsigned ASB_DATA_W     = 8;
	// offset within each bank; mirrored at 03h, 83h, 103h, 183h
	localparam logic [6:0]  ASB_STATUS_OFS = 7'h03;
	// field positions of alu_flags_and_bank_select
	localparam int unsigned ASB_IND_BANK_BIT = 7;
	localparam int unsigned ASB_DIR_HI_BIT   = 6;
	localparam int unsigned ASB_DIR_LO_BIT   = 5;
	localparam int unsigned ASB_TIMEOUT_BIT  = 4;
	localparam int unsigned ASB_PWRDN_BIT    = 3;
	localparam int unsigned ASB_ZERO_BIT     = 2;
	localparam int unsigned ASB_DCARRY_BIT   = 1;
	localparam int unsigned ASB_CARRY_BIT    = 0;
	// power-up value 0001 1xxx, unknown flags taken as zero
	localparam logic [7:0]  ASB_STATUS_RST   = 8'h18;
	localparam logic [2:0]  ASB_BANK_RST     = 3'h0;
	// operation classes presented by the core
	typedef enum logic [2:0] {
		ASB_OP_NONE = 3'h0, // move, bit set/clear, nibble swap: no flag effect
		ASB_OP_ADD  = 3'h1,
		ASB_OP_SUB  = 3'h2, // a minus b
		ASB_OP_AND  = 3'h3,
		ASB_OP_IOR  = 3'h4,
		ASB_OP_XOR  = 3'h5,
		ASB_OP_CLR  = 3'h6  // clear_file_instr
	} asb_op_e;
endpackage

// ==== pkg/asb_alu_if.sv ====
// interface between the status bank and its flag-producing alu
interface asb_alu_if;
	import asb_pkg::*;
	asb_op_e    op;
	logic [7:0] opa;
	logic [7:0] opb;
	logic [7:0] result;
	logic       zero;
	logic       dcarry;
	logic       carry;
	logic       upd_zero;
	logic       upd_carry;
	modport alu  (input op, opa, opb, output result, zero, dcarry, carry, upd_zero, upd_carry);
	modport bank (output op, opa, opb, input result, zero, dcarry, carry, upd_zero, upd_carry);
endinterface

// ==== design/asb_alu_flags.sv ====
// combinational result and zero / digit carry / carry generation
module asb_alu_flags
	import asb_pkg::*;
(
	asb_alu_if.alu a_if
);
	// subtraction is a + ~b + 1 so the carries come out as inverted borrows
	wire        is_add  = (a_if.op == ASB_OP_ADD);
	wire        is_sub  = (a_if.op == ASB_OP_SUB);
	wire [7:0]  addend  = is_sub ? ~a_if.opb : a_if.opb;
	wire [4:0]  low_sum = {1'b0, a_if.opa[3:0]} + {1'b0, addend[3:0]} + {4'h0, is_sub};
	wire [8:0]  sum     = {1'b0, a_if.opa} + {1'b0, addend} + {8'h00, is_sub};
	logic [7:0] res;

	// result select; pass-through keeps the core's pre-built byte
	always_comb begin
		case (a_if.op)
			ASB_OP_ADD,
			ASB_OP_SUB: res = sum[7:0];
			ASB_OP_AND: res = a_if.opa & a_if.opb;
			ASB_OP_IOR: res = a_if.opa | a_if.opb;
			ASB_OP_XOR: res = a_if.opa ^ a_if.opb;
			ASB_OP_CLR: res = 8'h00;
			default:    res = a_if.opa;
		endcase
	end

	// flags and which of them this operation owns
	assign a_if.result   = res;
	assign a_if.zero     = (res == 8'h00);
	assign a_if.dcarry   = low_sum[4];
	assign a_if.carry    = sum[8];
	assign a_if.upd_carry = is_add | is_sub;
	// no-flag class never claims the zero flag
	assign a_if.upd_zero = (a_if.op != ASB_OP_NONE);
endmodule // asb_alu_flags

// ==== design/asb_status_bank.sv ====
// processor status register: alu flags, reset cause and bank select
// Behaviour
// - status register decodes at offset 03h in every bank, one physical register
// - status accepts any instruction's result as destination in its writable bits
// - flag-updating instruction to status takes no data into zero, digit carry, carry; alu loads the ones it owns
// - writes never change timeout and power-down flags
// - clear-file to status zeroes bank bits, sets zero, keeps the rest
// - bit set/clear, swap, move-w-to-file leave zero, digit carry and carry untouched unless status is their destination, then they take the data
// - subtraction drives carry as inverted borrow, digit carry as inverted digit borrow
module asb_status_bank
	import asb_pkg::*;
#(
	parameter int unsigned DATA_W = ASB_DATA_W
)(
	input  wire logic       I_MCLK,
	input  wire logic       I_RST,         // power-up reset
	input  wire logic       I_OTHER_RST,   // external or watchdog reset
	input  wire logic       I_EXEC,        // one instruction executes this cycle
	input  wire asb_op_e    I_OP,
	input  wire logic [7:0] I_OPA,
	input  wire logic [7:0] I_OPB,
	input  wire logic       I_WR_EN,       // result goes to the addressed file
	input  wire logic       I_RD_EN,
	input  wire logic       I_INDIRECT,    // use pointer instead of direct field
	input  wire logic [6:0] I_FILE_ADDR,
	input  wire logic [7:0] I_PTR,
	input  wire logic       I_WDT_CLEAR,   // watchdog-clear instruction
	input  wire logic       I_SLEEP,       // sleep instruction
	input  wire logic       I_WDT_TIMEOUT,
	output logic      [8:0] O_DATA_ADDR,
	output logic            O_STATUS_HIT,
	output logic      [7:0] O_RD_DATA,
	output logic      [7:0] O_RESULT,
	output logic      [7:0] O_STATUS
);
	// only byte-wide operation is built
	if (DATA_W != 8) begin : g_width_check
		$error("asb_status_bank supports DATA_W = 8 only");
	end

	asb_alu_if  alu_if ();
	logic [7:0] status_q;
	logic [7:0] status_d;
	logic [7:0] rd_q;
	logic [7:0] res_q;

	asb_alu_flags u_alu (
		.a_if (alu_if.alu)
	);

	// operands straight from the core
	assign alu_if.op  = I_OP;
	assign alu_if.opa = I_OPA;
	assign alu_if.opb = I_OPB;

	// field views of the register
	wire       ind_bank  = status_q[ASB_IND_BANK_BIT];
	wire [1:0] dir_bank  = {status_q[ASB_DIR_HI_BIT], status_q[ASB_DIR_LO_BIT]};
	wire [8:0] ind_addr  = {ind_bank, I_PTR};
	wire [8:0] dir_addr  = {dir_bank, I_FILE_ADDR};
	wire [8:0] eff_addr  = I_INDIRECT ? ind_addr : dir_addr;
	// same offset in every bank hits the one register
	wire       hit       = (eff_addr[6:0] == ASB_STATUS_OFS);
	wire       wr_stat   = I_EXEC & I_WR_EN & hit;
	wire       upd_z     = I_EXEC & alu_if.upd_zero;
	wire       upd_dcc   = I_EXEC & alu_if.upd_carry;
	wire [7:0] wres      = alu_if.result;

	assign O_DATA_ADDR  = eff_addr;
	assign O_STATUS_HIT = hit;

	// next value of alu_flags_and_bank_select
	always_comb begin
		status_d = status_q;
		// bank bits: external or watchdog reset zeroes them, else they take the written data
		if (I_OTHER_RST) begin
			status_d[7:5] = ASB_BANK_RST;
		end else if (wr_stat) begin
			status_d[7:5] = wres[7:5];
		end
		if (I_WDT_TIMEOUT) begin
			status_d[ASB_TIMEOUT_BIT] = 1'b0;
		end else if (I_WDT_CLEAR | I_SLEEP) begin
			status_d[ASB_TIMEOUT_BIT] = 1'b1;
		end
		if (I_SLEEP) begin
			status_d[ASB_PWRDN_BIT] = 1'b0;
		end else if (I_WDT_CLEAR) begin
			status_d[ASB_PWRDN_BIT] = 1'b1;
		end
		// no data path into bits 4:3
		// a flag-owning op blocks the data write to all three flags
		if (wr_stat && !(alu_if.upd_zero || alu_if.upd_carry)) begin
			status_d[2:0] = wres[2:0];
		end
		if (upd_z) begin
			status_d[ASB_ZERO_BIT] = alu_if.zero;
		end
		// carries arrive already inverted for subtraction
		if (upd_dcc) begin
			status_d[ASB_DCARRY_BIT] = alu_if.dcarry;
			status_d[ASB_CARRY_BIT]  = alu_if.carry;
		end
	end

	always_ff @(posedge I_MCLK) begin
		if (I_RST) begin
			status_q <= ASB_STATUS_RST;
		end else begin
			status_q <= status_d;
		end
	end

	// read port and result are registered for timing
	always_ff @(posedge I_MCLK) begin
		if (I_RST) begin
			rd_q  <= 8'h00;
			res_q <= 8'h00;
		end else begin
			rd_q  <= (I_RD_EN && hit) ? status_q : 8'h00;
			res_q <= I_EXEC ? wres : res_q;
		end
	end

	assign O_RD_DATA = rd_q;
	assign O_RESULT  = res_q;
	assign O_STATUS  = status_q;

	default clocking cb @(posedge I_MCLK); endclocking
	default disable iff (I_RST);

	chk_mirror_read: assert property (
		(I_RD_EN && eff_addr[6:0] == 7'h03) |=> (O_RD_DATA == $past(status_q)))
		else $error("status read at mirror offset returned wrong data");

	chk_bank_write: assert property (
		(wr_stat && !I_OTHER_RST) |=> (status_q[7:5] == $past(wres[7:5])))
		else $error("bank bits not written from result");

	chk_flag_override: assert property (
		(wr_stat && I_OP == ASB_OP_ADD) |=>
		(status_q[2:0] == {$past(alu_if.zero), $past(alu_if.dcarry), $past(alu_if.carry)}))
		else $error("flags took data instead of alu outcome");

	chk_cause_hold: assert property (
		(wr_stat && !I_WDT_CLEAR && !I_SLEEP && !I_WDT_TIMEOUT) |=> $stable(status_q[4:3]))
		else $error("timeout or power-down flag changed by a write");

	chk_clear_file: assert property (
		(wr_stat && I_OP == ASB_OP_CLR) |=>
		(status_q[7:5] == 3'h0 && status_q[2] && status_q[1:0] == $past(status_q[1:0])))
		else $error("clear of status gave wrong pattern");

	// no flag change on plain moves
	chk_flags_kept: assert property (
		(I_EXEC && I_OP == ASB_OP_NONE && !wr_stat) |=> $stable(status_q[2:0]))
		else $error("flags changed on a non-flag instruction");

	chk_ind_bank: assert property (
		I_INDIRECT |-> (O_DATA_ADDR == {status_q[7], I_PTR}))
		else $error("indirect address not extended by bit 7");

	chk_dir_bank: assert property (
		!I_INDIRECT |-> (O_DATA_ADDR[8:7] == status_q[6:5]))
		else $error("direct bank select wrong");

	chk_sub_borrow: assert property (
		(I_EXEC && I_OP == ASB_OP_SUB && !wr_stat) |=>
		(status_q[0] == ($past(I_OPA) >= $past(I_OPB)) &&
		 status_q[1] == ($past(I_OPA[3:0]) >= $past(I_OPB[3:0]))))
		else $error("subtraction borrow flags wrong");

	// zero flag tracks a zero result
	chk_zero_flag: assert property (
		(I_EXEC && I_OP != ASB_OP_NONE && !wr_stat) |=>
		(status_q[2] == ($past(wres) == 8'h00)))
		else $error("zero flag disagrees with result");

	chk_sleep_cause: assert property (
		(I_SLEEP && !I_WDT_TIMEOUT && !I_WDT_CLEAR) |=> (status_q[4:3] == 2'b10))
		else $error("sleep did not mark timeout and power-down");

	// read port idles at zero without a status read
	chk_rd_idle: assert property (
		!(I_RD_EN && hit) |=> (O_RD_DATA == 8'h00))
		else $error("read port not zero without a status read");

	// add carries come from bit 3 and bit 7, worked from the operands
	chk_add_carry: assert property (
		(I_EXEC && I_OP == ASB_OP_ADD) |=>
		(status_q[0] == (({1'b0, $past(I_OPA)} + {1'b0, $past(I_OPB)}) > 9'h0ff) &&
		 status_q[1] == (({1'b0, $past(I_OPA[3:0])} + {1'b0, $past(I_OPB[3:0])}) > 5'h0f)))
		else $error("add carry flags wrong");

	// logic and clear operations own only the zero flag
	chk_logic_carry: assert property (
		(I_EXEC && (I_OP inside {ASB_OP_AND, ASB_OP_IOR, ASB_OP_XOR, ASB_OP_CLR})) |=>
		$stable(status_q[1:0]))
		else $error("logic operation changed a carry flag");

	// logic result is registered on execute
	chk_and_result: assert property (
		(I_EXEC && I_OP == ASB_OP_AND) |=> (O_RESULT == ($past(I_OPA) & $past(I_OPB))))
		else $error("logic result wrong");

	// watchdog expiry clears timeout whatever else happens
	chk_wdt_expiry: assert property (
		I_WDT_TIMEOUT |=> !status_q[ASB_TIMEOUT_BIT])
		else $error("watchdog expiry left timeout flag set");

	// watchdog clear alone sets both cause flags
	chk_wdt_clear: assert property (
		(I_WDT_CLEAR && !I_SLEEP && !I_WDT_TIMEOUT) |=> (status_q[4:3] == 2'b11))
		else $error("watchdog clear did not set both cause flags");
endmodule // asb_status_bank

// ==== verif/asb_core_model.sv ====
// core-side model: issues random instructions and reset-cause events
module asb_core_model
	import asb_pkg::*;
(
	output logic       o_exec,
	output asb_op_e    o_op,
	output logic [7:0] o_opa,
	output logic [7:0] o_opb,
	output logic       o_wr_en,
	output logic       o_rd_en,
	output logic       o_indirect,
	output logic [6:0] o_file_addr,
	output logic [7:0] o_ptr,
	output logic       o_wdt_clear,
	output logic       o_sleep,
	output logic       o_wdt_timeout,
	output logic       o_other_rst
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle until the bench issues the first instruction
	initial begin
		{o_exec, o_opa, o_opb, o_wr_en, o_rd_en, o_indirect, o_file_addr} = '0;
		{o_ptr, o_wdt_clear, o_sleep, o_wdt_timeout, o_other_rst} = '0;
		o_op = ASB_OP_NONE;
	end
	// half the accesses aim at the status offset so writes land often
	task automatic drive();
		o_exec        = 1'($urandom);
		o_op          = asb_op_e'($urandom_range(0, 6));
		o_opa         = 8'($urandom);
		o_opb         = 8'($urandom);
		o_wr_en       = 1'($urandom);
		o_rd_en       = 1'($urandom);
		o_indirect    = 1'($urandom);
		o_file_addr   = $urandom_range(0, 1) ? 7'h03 : 7'($urandom);
		o_ptr         = {1'($urandom), ($urandom_range(0, 1) ? 7'h03 : 7'($urandom))};
		// events kept rare so written bits survive long enough to be seen
		o_wdt_clear   = ($urandom_range(0, 7) == 0);
		o_sleep       = ($urandom_range(0, 7) == 0);
		o_wdt_timeout = ($urandom_range(0, 7) == 0);
		o_other_rst   = ($urandom_range(0, 15) == 0);
	endtask
endmodule // asb_core_model

// ==== verif/tb.sv ====
// testbench: random core traffic checked against a status register model
module tb
	import asb_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic       I_MCLK, I_RST, e, wr, rd, ind, clr, slp, tmo, orst, hit;
	asb_op_e    op;
	logic [7:0] a, b, ptr, st, nst, eres, erd;
	logic [6:0] fa;
	logic [8:0] O_DATA_ADDR;
	logic       O_STATUS_HIT;
	logic [7:0] O_RD_DATA, O_RESULT, O_STATUS;
	int         r, failures, comparisons;
	asb_core_model core (.o_exec(e), .o_op(op), .o_opa(a), .o_opb(b), .o_wr_en(wr),
		.o_rd_en(rd), .o_indirect(ind), .o_file_addr(fa), .o_ptr(ptr), .o_wdt_clear(clr),
		.o_sleep(slp), .o_wdt_timeout(tmo), .o_other_rst(orst));
	asb_status_bank dut (.I_MCLK(I_MCLK), .I_RST(I_RST), .I_OTHER_RST(orst), .I_EXEC(e),
		.I_OP(op), .I_OPA(a), .I_OPB(b), .I_WR_EN(wr), .I_RD_EN(rd), .I_INDIRECT(ind),
		.I_FILE_ADDR(fa), .I_PTR(ptr), .I_WDT_CLEAR(clr), .I_SLEEP(slp),
		.I_WDT_TIMEOUT(tmo), .O_DATA_ADDR(O_DATA_ADDR), .O_STATUS_HIT(O_STATUS_HIT),
		.O_RD_DATA(O_RD_DATA), .O_RESULT(O_RESULT), .O_STATUS(O_STATUS));
	// free-running core clock
	initial begin
		I_MCLK = 1'b0;
		forever #4 I_MCLK = ~I_MCLK;
	end
	// one compare; an unknown matches only an identical unknown
	task automatic chk(input logic [8:0] got, input logic [8:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic print_verdict();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// every edge: check registered outputs, then issue and predict the next one
	initial begin
		I_RST = 1'b1;
		void'($urandom(32'h6d65));
		repeat (16) @(posedge I_MCLK);
		#1 I_RST = 1'b0;
		{nst, eres, erd} = {ASB_STATUS_RST, 16'h0};
		repeat (2000) begin
			@(posedge I_MCLK);
			#1;
			st = nst;
			chk(O_STATUS, st);
			chk(O_RESULT, eres);
			chk(O_RD_DATA, erd);
			core.drive();
			#1;
			hit = ind ? (ptr[6:0] == 7'h03) : (fa == 7'h03);
			chk(O_DATA_ADDR, ind ? {st[7], ptr} : {st[6:5], fa});
			chk(O_STATUS_HIT, hit);
			case (op)
				ASB_OP_ADD: r = a + b;
				ASB_OP_SUB: r = a - b;
				ASB_OP_AND: r = a & b;
				ASB_OP_IOR: r = a | b;
				ASB_OP_XOR: r = a ^ b;
				ASB_OP_CLR: r = 0;
				default:    r = a;
			endcase
			nst = st;
			erd = (rd && hit) ? st : 8'h00;
			if (e) eres = 8'(r);
			if (e && wr && hit) nst = (op == ASB_OP_NONE) ? (st & 8'h18) | (8'(r) & 8'he7)
				: (st & 8'h1f) | (8'(r) & 8'he0);
			if (e && op != ASB_OP_NONE) begin
				nst[2] = (8'(r) == 8'h00);
				if (op == ASB_OP_ADD) nst[1:0] = {(a & 15) + (b & 15) > 15, a + b > 255};
				if (op == ASB_OP_SUB) nst[1:0] = {(a & 15) >= (b & 15), a >= b};
			end
			if (orst) nst[7:5] = 3'h0;
			if (clr) nst[4:3] = 2'b11;
			if (slp) nst[4:3] = 2'b10;
			if (tmo) nst[4] = 1'b0;
		end
		print_verdict();
	end
endmodule // tb
